// ### faoc_pkg.sv
package faoc_pkg;
    // clock rate in kHz
    localparam int CLK_KHZ = 50000;
    // bus timing figures in ns
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 35;
    localparam int T_ACC_NS = 90;
    localparam int T_DF_NS = 25;
    localparam int T_RP_NS = 500;
    localparam int T_AH_NS = 35;
    // least times round up
    localparam int WP_CYC = (T_WP_NS * CLK_KHZ + 999999) / 1000000;
    localparam int WPH_CYC = (T_WPH_NS * CLK_KHZ + 999999) / 1000000;
    localparam int ACC_CYC = (T_ACC_NS * CLK_KHZ + 999999) / 1000000 + 1;
    localparam int DF_CYC = (T_DF_NS * CLK_KHZ + 999999) / 1000000;
    localparam int RP_CYC = (T_RP_NS * CLK_KHZ + 999999) / 1000000;
    localparam int AH_CYC = (T_AH_NS * CLK_KHZ + 999999) / 1000000;
    // operation time limits in us
    localparam int T_BP_MAX_US = 200;
    localparam int T_BPD_MAX_US = 100;
    localparam int T_ES_MAX_US = 15;
    localparam int T_PS_MAX_US = 10;
    // erase limits in ms
    localparam int T_EC_TYP_MS = 25000;
    localparam int T_SEC1_MAX_MS = 3000;
    localparam int T_SEC2_MAX_MS = 5000;
    localparam int US_CYC = CLK_KHZ / 1000;
    // command addresses and data
    localparam logic [19:0] ADDR_555 = 20'h00555;
    localparam logic [19:0] ADDR_AAA = 20'h00aaa;
    localparam logic [7:0] D_AA = 8'haa;
    localparam logic [7:0] D_55 = 8'h55;
    localparam logic [7:0] D_80 = 8'h80;
    localparam logic [7:0] D_CHIP = 8'h10;
    localparam logic [7:0] D_SECT = 8'h30;
    localparam logic [7:0] D_PROG = 8'ha0;
    localparam logic [7:0] D_SUSP = 8'hb0;
    localparam logic [7:0] D_IDENT = 8'h90;
    localparam logic [7:0] D_EXIT = 8'hf0;
    // protection register: bit 7 set, index+1 in low bits
    localparam logic [19:0] PROT_BASE = 20'h00080;
    localparam int PROT_WORDS = 8;
    // sector map
    localparam logic [19:0] TOP_SMALL_BASE = 20'hf8000;
    localparam logic [19:0] BOT_SMALL_END = 20'h07fff;
    localparam int STATUS_TIMEOUT_BIT = 5;
    localparam int STATUS_TOGGLE_BIT = 6;
    // host operations
    typedef enum logic [2:0] {
        OP_READ, OP_PROG, OP_CHIP_ERASE, OP_SECT_ERASE,
        OP_SUSPEND, OP_ID_READ, OP_PROT_READ
    } faoc_op_t;
endpackage

// ### faoc_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// one asynchronous bus cycle: read or write, timed in clock cycles
module faoc_cycle (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic wr_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [15:0] dq_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic [19:0] addr_o,
    output logic [15:0] dq_o,
    output logic dq_oe_n_o
);
    typedef enum logic [2:0] {S_IDLE, S_SET, S_PULSE, S_HOLD, S_GAP}
        faoc_cyc_t;
    faoc_cyc_t st, next_st;
    logic [7:0] cnt, next_cnt;
    logic wr, next_wr;
    logic [19:0] addr, next_addr;
    logic [15:0] wdata, next_wdata, rdata, next_rdata;
    localparam logic [7:0] WP = 8'(faoc_pkg::WP_CYC);
    localparam logic [7:0] ACC = 8'(faoc_pkg::ACC_CYC);
    localparam logic [7:0] GAP = 8'(faoc_pkg::WPH_CYC + faoc_pkg::DF_CYC);

    // sequence: address setup, strobe pulse, release, recovery gap
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_wr = wr;
        next_addr = addr;
        next_wdata = wdata;
        next_rdata = rdata;
        done_o = 1'b0;
        unique case (st)
            S_IDLE: begin
                if (start_i) begin
                    next_wr = wr_i;
                    next_addr = addr_i;
                    next_wdata = wdata_i;
                    next_st = S_SET;
                end
            end
            S_SET: begin
                next_cnt = wr ? WP : ACC;
                next_st = S_PULSE;
            end
            S_PULSE: begin
                if (cnt <= 8'h01) begin
                    if (!wr) next_rdata = dq_i;
                    next_st = S_HOLD;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            S_HOLD: begin
                next_cnt = GAP;
                next_st = S_GAP;
            end
            S_GAP: begin
                if (cnt <= 8'h01) begin
                    done_o = 1'b1;
                    next_st = S_IDLE;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= S_IDLE;
            cnt <= 8'h00;
            wr <= 1'b0;
            addr <= 20'h00000;
            wdata <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            wr <= next_wr;
            addr <= next_addr;
            wdata <= next_wdata;
            rdata <= next_rdata;
        end
    end

    // oe stays high whenever we and ce are low together [R15] [R06]
    assign ce_n_o = !(st == S_PULSE || st == S_SET || st == S_HOLD);
    assign we_n_o = !(wr && st == S_PULSE);
    assign oe_n_o = !(!wr && (st == S_PULSE || st == S_SET));
    assign addr_o = addr;
    assign dq_o = wdata;
    // drive data only on writes; release on reads [R05] [R06]
    assign dq_oe_n_o = !(wr && st != S_IDLE && st != S_GAP);
    assign rdata_o = rdata;
endmodule
`default_nettype wire

// ### faoc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R01 - protection word n at bit7 plus n+1
// R02 - protection access keeps address 19..8 zero
// R03 - bottom boot: eight 4K then 32K sectors
// R04 - top boot: 32K sectors then eight 4K
// R05 - read: ce low, oe low, we high
// R06 - write: ce low, oe high, we low, vpp high
// R07 - device inhibits program on bad controls
// R08 - ce high means standby, data high-z
// R09 - oe high keeps device outputs off
// R10 - reset low tri-states and ignores device
// R11 - hardware id uses elevated a9 voltage
// R12 - software id read at address 0 or 1
// R13 - chip erase 555, sector erase sector address
// R14 - final erase data 10 chip, 30 sector
// R15 - oe high while we and ce low
// R16 - word program at most 200 us
// R17 - chip erase busy typically 25 seconds
// R18 - sector erase within 3 or 5 seconds
// R19 - suspend halts within 15 or 10 us; the host allows 15 us for every suspend
// R20 - erase is six command writes
// R21 - ready/busy low while operation runs
// R22 - status bit 5 flags timeout
// R23 - sector index from upper address bits
module faoc_ctrl #(
    parameter bit TOP_BOOT = 1'b0,
    parameter int US_CYC = faoc_pkg::US_CYC,
    parameter int MS_CYC = faoc_pkg::CLK_KHZ,
    parameter int RST_CYC = faoc_pkg::RP_CYC
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic REQ_VALID_I,
    output logic REQ_READY_O,
    input wire logic [2:0] REQ_OP_I,
    input wire logic [19:0] REQ_ADDR_I,
    input wire logic [15:0] REQ_DATA_I,
    output logic RSP_VALID_O,
    output logic [15:0] RSP_DATA_O,
    output logic RSP_ERROR_O,
    output logic [5:0] RSP_SECTOR_O,
    output logic FLASH_CE_N_O,
    output logic FLASH_OE_N_O,
    output logic FLASH_WE_N_O,
    output logic FLASH_RESET_N_O,
    output logic FLASH_VPP_HIGH_O,
    output logic FLASH_ID_HV_O,
    output logic [19:0] FLASH_ADDR_O,
    output logic [15:0] FLASH_DQ_O,
    output logic FLASH_DQ_OE_N_O,
    input wire logic [15:0] FLASH_DQ_I,
    input wire logic FLASH_RDY_I
);
    // refuse counts that the counters cannot hold
    localparam bit BAD_COUNT = US_CYC < 1 || MS_CYC < 1 || RST_CYC < 1
        || RST_CYC >= 32'h00010000;
    if (BAD_COUNT) begin : g_bad_count
        $error("faoc_ctrl: count parameters out of range");
    end

    // sector index decode, used only for the response sector output [R23]
    function automatic logic [5:0] sector_of(input logic [19:0] a);
        if (!TOP_BOOT) begin
            if (a <= faoc_pkg::BOT_SMALL_END) sector_of = {3'h0, a[14:12]}; // [R03]
            else sector_of = 6'(a[19:15]) + 6'h07; // [R03]
        end else begin
            if (a >= faoc_pkg::TOP_SMALL_BASE)
                sector_of = 6'h1f + {3'h0, a[14:12]}; // [R04]
            else sector_of = {1'b0, a[19:15]}; // [R04]
        end
    endfunction

    function automatic logic small_sector(input logic [19:0] a);
        small_sector = TOP_BOOT ? (a >= faoc_pkg::TOP_SMALL_BASE)
                                : (a <= faoc_pkg::BOT_SMALL_END);
    endfunction

    typedef enum logic [2:0] {C_RST, C_IDLE, C_CMD, C_WAIT, C_POLL, C_RESP}
        faoc_st_t;
    faoc_st_t st, next_st;
    faoc_pkg::faoc_op_t op, next_op;
    logic [19:0] addr, next_addr;
    logic [15:0] data, next_data, rsp, next_rsp;
    logic [2:0] step, next_step;
    logic [35:0] tmo, next_tmo;
    logic err, next_err;
    logic [15:0] rcnt, next_rcnt;
    logic [5:0] sect, next_sect;
    logic cyc_start, cyc_wr, cyc_done;
    logic [19:0] cyc_addr;
    logic [15:0] cyc_wdata, cyc_rdata;
    logic [2:0] nsteps;

    // command word for step k of the sequence
    always_comb begin
        cyc_addr = faoc_pkg::ADDR_555;
        cyc_wdata = {8'h00, faoc_pkg::D_AA};
        cyc_wr = 1'b1;
        nsteps = 3'd1;
        unique case (op)
            faoc_pkg::OP_READ, faoc_pkg::OP_PROT_READ: begin
                cyc_wr = 1'b0;
                cyc_addr = addr;
            end
            faoc_pkg::OP_SUSPEND: begin
                cyc_wdata = {8'h00, faoc_pkg::D_SUSP};
            end
            faoc_pkg::OP_PROG: begin
                nsteps = 3'd4;
                if (step[0]) cyc_addr = faoc_pkg::ADDR_AAA;
                if (step[0]) cyc_wdata = {8'h00, faoc_pkg::D_55};
                if (step == 3'd2) cyc_wdata = {8'h00, faoc_pkg::D_PROG};
                if (step == 3'd3) cyc_addr = addr;
                if (step == 3'd3) cyc_wdata = data;
            end
            faoc_pkg::OP_ID_READ: begin
                // entry, read code, exit [R12]
                nsteps = 3'd5;
                if (step[0] && step != 3'd3) cyc_addr = faoc_pkg::ADDR_AAA;
                if (step[0] && step != 3'd3) cyc_wdata = {8'h00, faoc_pkg::D_55};
                if (step == 3'd2) cyc_wdata = {8'h00, faoc_pkg::D_IDENT};
                if (step == 3'd3) cyc_wr = 1'b0;
                if (step == 3'd3) cyc_addr = {19'h00000, addr[0]}; // [R12]
                if (step == 3'd4) cyc_wdata = {8'h00, faoc_pkg::D_EXIT};
            end
            default: begin
                // six-write erase sequence: AA 55 80 AA 55 final [R20]
                nsteps = 3'd6;
                if (step == 3'd1 || step == 3'd4) begin
                    cyc_addr = faoc_pkg::ADDR_AAA;
                    cyc_wdata = {8'h00, faoc_pkg::D_55};
                end
                if (step == 3'd2) cyc_wdata = {8'h00, faoc_pkg::D_80};
                if (step == 3'd5) begin
                    // final address and code [R13] [R14]
                    cyc_addr = (op == faoc_pkg::OP_SECT_ERASE) ? addr
                                                        : faoc_pkg::ADDR_555;
                    cyc_wdata = (op == faoc_pkg::OP_SECT_ERASE)
                        ? {8'h00, faoc_pkg::D_SECT} : {8'h00, faoc_pkg::D_CHIP};
                end
            end
        endcase
    end

    // busy limit per operation [R16] [R17] [R18] [R19]
    function automatic logic [35:0] limit_of(input faoc_pkg::faoc_op_t o,
                                             input logic [19:0] a);
        unique case (o)
            faoc_pkg::OP_PROG: limit_of = 36'(faoc_pkg::T_BP_MAX_US * US_CYC);
            faoc_pkg::OP_SUSPEND: limit_of = 36'(faoc_pkg::T_ES_MAX_US * US_CYC);
            faoc_pkg::OP_CHIP_ERASE:
                limit_of = 36'(2 * faoc_pkg::T_EC_TYP_MS) * 36'(MS_CYC);
            faoc_pkg::OP_SECT_ERASE: limit_of = small_sector(a)
                ? 36'(faoc_pkg::T_SEC1_MAX_MS) * 36'(MS_CYC)
                : 36'(faoc_pkg::T_SEC2_MAX_MS) * 36'(MS_CYC);
            default: limit_of = 36'h0;
        endcase
    endfunction

    // request sequencing and completion wait
    always_comb begin
        next_st = st;
        next_op = op;
        next_addr = addr;
        next_data = data;
        next_rsp = rsp;
        next_step = step;
        next_tmo = tmo;
        next_err = err;
        next_rcnt = rcnt;
        cyc_start = 1'b0;
        unique case (st)
            C_RST: begin
                if (rcnt <= 16'h0001) next_st = C_IDLE;
                else next_rcnt = rcnt - 16'h0001;
            end
            C_IDLE: begin
                if (REQ_VALID_I) begin
                    next_op = faoc_pkg::faoc_op_t'(REQ_OP_I);
                    next_addr = REQ_ADDR_I;
                    // protection word index n sits at bit 7, n+1 [R01] [R02]
                    if (REQ_OP_I == 3'(faoc_pkg::OP_PROT_READ))
                        next_addr = faoc_pkg::PROT_BASE
                            + {16'h0000, 4'(REQ_ADDR_I[2:0]) + 4'h1};
                    next_data = REQ_DATA_I;
                    next_step = 3'd0;
                    next_err = 1'b0;
                    next_st = C_CMD;
                end
            end
            C_CMD: begin
                cyc_start = 1'b1;
                next_st = C_WAIT;
            end
            C_WAIT: begin
                if (cyc_done) begin
                    if (!cyc_wr) next_rsp = cyc_rdata;
                    if (step + 3'd1 < nsteps) begin
                        next_step = step + 3'd1;
                        next_st = C_CMD;
                    end else if (limit_of(op, addr) != 36'h0) begin
                        next_tmo = limit_of(op, addr);
                        next_st = C_POLL;
                    end else begin
                        next_st = C_RESP;
                    end
                end
            end
            C_POLL: begin
                // ready/busy high ends the wait; the host also times out
                if (FLASH_RDY_I) begin // [R21]
                    next_st = C_RESP;
                end else if (tmo <= 36'h1) begin
                    next_err = 1'b1;
                    next_st = C_RESP;
                end else begin
                    next_tmo = tmo - 36'h1;
                end
            end
            C_RESP: next_st = C_IDLE;
            default: next_st = C_IDLE;
        endcase
        // sector index kept in a flip-flop for the sector output
        next_sect = sector_of(next_addr); // [R23]
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st <= C_RST;
            op <= faoc_pkg::OP_READ;
            addr <= 20'h00000;
            data <= 16'h0000;
            rsp <= 16'h0000;
            step <= 3'd0;
            tmo <= 36'h0;
            err <= 1'b0;
            rcnt <= 16'(RST_CYC);
            sect <= 6'h00;
        end else begin
            st <= next_st;
            op <= next_op;
            addr <= next_addr;
            data <= next_data;
            rsp <= next_rsp;
            step <= next_step;
            tmo <= next_tmo;
            err <= next_err;
            rcnt <= next_rcnt;
            sect <= next_sect;
        end
    end

    faoc_cycle u_cycle (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .start_i(cyc_start),
        .wr_i(cyc_wr),
        .addr_i(cyc_addr),
        .wdata_i(cyc_wdata),
        .dq_i(FLASH_DQ_I),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .ce_n_o(FLASH_CE_N_O),
        .oe_n_o(FLASH_OE_N_O),
        .we_n_o(FLASH_WE_N_O),
        .addr_o(FLASH_ADDR_O),
        .dq_o(FLASH_DQ_O),
        .dq_oe_n_o(FLASH_DQ_OE_N_O)
    );

    // flash reset held low for the pulse width after our own reset
    assign FLASH_RESET_N_O = (st != C_RST);
    // program supply held high once the flash is out of reset [R06]
    assign FLASH_VPP_HIGH_O = (st != C_RST);
    // elevated a9 is not used: software id reads only [R11]
    assign FLASH_ID_HV_O = 1'b0;
    assign REQ_READY_O = (st == C_IDLE);
    assign RSP_VALID_O = (st == C_RESP);
    assign RSP_DATA_O = rsp;
    // host timeout stands in for status bit 5; no status read [R22]
    assign RSP_ERROR_O = err;
    assign RSP_SECTOR_O = sect;
endmodule
`default_nettype wire

// ### faoc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches the flash strobes and the request handshake at the top ports
module faoc_ctrl_chk (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic REQ_VALID_I,
    input wire logic REQ_READY_O,
    input wire logic RSP_VALID_O,
    input wire logic FLASH_CE_N_O,
    input wire logic FLASH_OE_N_O,
    input wire logic FLASH_WE_N_O,
    input wire logic FLASH_RESET_N_O,
    input wire logic FLASH_VPP_HIGH_O,
    input wire logic [19:0] FLASH_ADDR_O,
    input wire logic FLASH_DQ_OE_N_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // a read never overlaps a write strobe
    rd_no_we_a: assert property (!FLASH_OE_N_O |-> FLASH_WE_N_O)
        else $error("output enable and write enable low together");
    // host lets go of the data lines while the device may drive them
    rd_float_a: assert property (
        !FLASH_OE_N_O |-> FLASH_DQ_OE_N_O && !FLASH_CE_N_O)
        else $error("host drives data during a read");
    // a write pulse only in the program/erase bus mode
    wr_mode_a: assert property (!FLASH_WE_N_O |-> !FLASH_CE_N_O &&
        FLASH_OE_N_O && !FLASH_DQ_OE_N_O && FLASH_VPP_HIGH_O)
        else $error("write pulse outside program mode");
    // two cycles cover the 35 ns least pulse width
    wp_width_a: assert property (
        $fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*2])
        else $error("write pulse too short");
    // address held past the end of the pulse
    addr_hold_a: assert property (
        $rose(FLASH_WE_N_O) |-> $stable(FLASH_ADDR_O) [*2])
        else $error("address changed too soon after write");
    // device in reset sees no strobes and no request is taken
    reset_idle_a: assert property (!FLASH_RESET_N_O |-> FLASH_CE_N_O &&
        FLASH_OE_N_O && FLASH_WE_N_O && !REQ_READY_O)
        else $error("strobes active during flash reset");
    // idle means the device is in standby
    idle_stby_a: assert property (
        REQ_READY_O |-> FLASH_CE_N_O && FLASH_DQ_OE_N_O)
        else $error("chip select low while idle");
    // a taken request ends the idle state
    take_busy_a: assert property (
        REQ_VALID_I && REQ_READY_O |=> !REQ_READY_O)
        else $error("ready stayed high after a request");
    // the answer is a single-cycle pulse
    rsp_pulse_a: assert property (RSP_VALID_O |=> !RSP_VALID_O)
        else $error("response valid longer than one cycle");
endmodule
bind faoc_ctrl faoc_ctrl_chk chk_u (.CLK_I, .RSTN_I, .REQ_VALID_I,
    .REQ_READY_O, .RSP_VALID_O, .FLASH_CE_N_O, .FLASH_OE_N_O,
    .FLASH_WE_N_O, .FLASH_RESET_N_O, .FLASH_VPP_HIGH_O, .FLASH_ADDR_O,
    .FLASH_DQ_OE_N_O);
`default_nettype wire

// ### faoc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural bottom-boot flash; counts busy time in bench clocks
module faoc_flash_model #(
    parameter logic [15:0] MFR_CODE = 16'h0a5a, // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h0b6b // arbitrary value
) (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rst_n_i,
    input wire logic vpp_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic rdy_o
);
    logic [15:0] mem [logic [19:0]];
    logic [2:0] step = 3'h0;
    logic id_mode = 1'b0;
    logic prog_next = 1'b0;
    logic wr_on = 1'b0;
    logic [19:0] wa = 20'h0;
    logic [15:0] wd = 16'h0;
    logic [7:0] last_code = 8'h0;
    logic [19:0] last_addr = 20'h0;
    logic [15:0] last_out = 16'h0;
    int busy = 0;
    // sector index of a word address
    function automatic int sect(input logic [19:0] a);
        return (a < 20'h08000) ? int'(a[14:12]) : int'(a[19:15]) + 7;
    endfunction
    // protection words sit at 0x81..0x88, upper lines zero
    function automatic logic [15:0] rd_val(input logic [19:0] a);
        if (a[19:8] == 12'h0 && a[7] && a[6:4] == 3'h0 && a[3:0] != 4'h0
            && a[3:0] <= 4'h8) return 16'hc0cf + {12'h0, a[3:0]};
        if (id_mode && a[19:1] == 19'h0) return a[0] ? DEV_CODE : MFR_CODE;
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    // released lines show the inverse of the last word, not a stale copy
    always @* begin
        if (rst_n_i && !ce_n_i && !oe_n_i && we_n_i) begin
            dq_o = rd_val(addr_i);
            last_out = dq_o;
        end else dq_o = ~last_out;
    end
    assign rdy_o = (busy == 0);
    // decode one completed bus write
    task automatic take_write(input logic [19:0] a, input logic [15:0] d);
        logic [19:0] ks[$];
        if (d[7:0] == 8'hb0) begin
            if (busy > 4) busy = 4;
        end else if (busy != 0) begin
        end else if (d[7:0] == 8'hf0) begin
            id_mode = 1'b0;
            step = 3'h0;
        end else if (prog_next) begin
            mem[a] = d;
            prog_next = 1'b0;
            busy = slow_i ? 500 : 20;
        end else if (d[7:0] == 8'haa && a[10:0] == 11'h555 && step % 3 == 0)
            step = step + 3'h1;
        else if (d[7:0] == 8'h55 && a[10:0] == 11'h2aa && step % 3 == 1)
            step = step + 3'h1;
        else if (step == 3'h2 && a[10:0] == 11'h555) begin
            step = (d[7:0] == 8'h80) ? 3'h3 : 3'h0;
            if (d[7:0] == 8'h90) id_mode = 1'b1;
            if (d[7:0] == 8'ha0) prog_next = 1'b1;
        end else if (step == 3'h5) begin
            last_code = d[7:0];
            last_addr = a;
            step = 3'h0;
            if (d[7:0] == 8'h10 && a[10:0] == 11'h555) begin
                mem.delete();
                busy = 60;
            end else if (d[7:0] == 8'h30) begin
                foreach (mem[k]) if (sect(k) == sect(a)) ks.push_back(k);
                foreach (ks[i]) mem.delete(ks[i]);
                busy = 50;
            end
        end else step = 3'h0;
    endtask
    // sample on the falling edge, away from the host's register updates
    always @(negedge clk_i) begin
        if (busy > 0) busy = busy - 1;
        if (!rst_n_i) begin
            step = 3'h0;
            id_mode = 1'b0;
            prog_next = 1'b0;
        end else if (wr_on && we_n_i) take_write(wa, wd);
        wr_on = rst_n_i && !ce_n_i && oe_n_i && !we_n_i && vpp_i;
        wa = addr_i;
        wd = dq_i;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int RST_CYC = 25;
    logic clk, rstn, req_valid, req_ready, rsp_valid, rsp_error, slow;
    logic [2:0] req_op;
    logic [19:0] req_addr, faddr;
    logic [15:0] req_data, rsp_data, fdq_o, fdq_i;
    logic [5:0] rsp_sector;
    logic ce_n, oe_n, we_n, frst_n, vpp, id_hv, fdq_oe_n, rdy;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    faoc_ctrl #(.TOP_BOOT(1'b0), .US_CYC(2), .MS_CYC(10), .RST_CYC(RST_CYC))
    dut_u (.CLK_I(clk), .RSTN_I(rstn), .REQ_VALID_I(req_valid),
        .REQ_READY_O(req_ready), .REQ_OP_I(req_op), .REQ_ADDR_I(req_addr),
        .REQ_DATA_I(req_data), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
        .RSP_ERROR_O(rsp_error), .RSP_SECTOR_O(rsp_sector),
        .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n),
        .FLASH_RESET_N_O(frst_n), .FLASH_VPP_HIGH_O(vpp),
        .FLASH_ID_HV_O(id_hv), .FLASH_ADDR_O(faddr), .FLASH_DQ_O(fdq_o),
        .FLASH_DQ_OE_N_O(fdq_oe_n), .FLASH_DQ_I(fdq_i), .FLASH_RDY_I(rdy));
    faoc_flash_model flash_u (.clk_i(clk), .slow_i(slow), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .rst_n_i(frst_n), .vpp_i(vpp),
        .addr_i(faddr), .dq_i(fdq_o), .dq_o(fdq_i), .rdy_o(rdy));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one request: held until taken, then wait for the one-cycle answer
    task automatic do_req(input logic [2:0] op, input logic [19:0] a,
                          input logic [15:0] d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_data = d;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check(20'(n < 5000), 20'h1);
        @(negedge clk);
    endtask
    // flash reset held at least 500 ns before the first request
    task automatic t_reset;
        int n;
        n = 0;
        check(20'(frst_n), 20'h0);
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(20'(n == RST_CYC), 20'h1);
        check(20'({frst_n, vpp, id_hv}), 20'h6);
    endtask
    // prompt program, read back, then a program that overruns its limit
    task automatic t_prog;
        do_req(3'h1, 20'h12345, 16'h5a3c);
        check(20'(rsp_error), 20'h0);
        do_req(3'h0, 20'h12345, 16'h0);
        check(20'(rsp_data), 20'h05a3c);
        slow = 1'b1;
        do_req(3'h1, 20'h12346, 16'h0f0f);
        check(20'(rsp_error), 20'h1);
        slow = 1'b0;
        repeat (150) @(negedge clk);
    endtask
    // small sector erase spares its neighbour; decode at the boundaries
    task automatic t_sect;
        do_req(3'h1, 20'h03000, 16'h1111);
        do_req(3'h1, 20'h04000, 16'h2222);
        do_req(3'h3, 20'h03abc, 16'h0);
        check(20'({rsp_error, rsp_sector}), 20'h3);
        check(20'(flash_u.last_code), 20'h30);
        check(flash_u.last_addr, 20'h03abc);
        do_req(3'h0, 20'h03000, 16'h0);
        check(20'(rsp_data), 20'h0ffff);
        do_req(3'h0, 20'h04000, 16'h0);
        check(20'(rsp_data), 20'h02222);
        do_req(3'h0, 20'h07fff, 16'h0);
        check(20'(rsp_sector), 20'h7);
        do_req(3'h0, 20'h08000, 16'h0);
        check(20'(rsp_sector), 20'h8);
        do_req(3'h3, 20'h9a000, 16'h0);
        check(20'({rsp_error, rsp_sector}), 20'd26);
    endtask
    // chip erase clears a word programmed at 0x50000
    task automatic t_chip;
        do_req(3'h1, 20'h50000, 16'h3333);
        do_req(3'h2, 20'h0, 16'h0);
        check(20'(rsp_error), 20'h0);
        check(20'(flash_u.last_code), 20'h10);
        check(20'(flash_u.last_addr[10:0]), 20'h555);
        do_req(3'h0, 20'h50000, 16'h0);
        check(20'(rsp_data), 20'h0ffff);
    endtask
    // identification codes, protection words and a suspend
    task automatic t_misc;
        do_req(3'h5, 20'h0, 16'h0);
        check(20'(rsp_data), 20'h00a5a);
        do_req(3'h5, 20'h1, 16'h0);
        check(20'(rsp_data), 20'h00b6b);
        for (int i = 0; i < 8; i++) begin
            do_req(3'h6, 20'(i), 16'h0);
            check(20'(rsp_data), 20'hc0d0 + 20'(i));
        end
        do_req(3'h4, 20'h0, 16'h0);
        check(20'(rsp_error), 20'h0);
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_op = 3'h0;
        req_addr = 20'h0;
        req_data = 16'h0;
        slow = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        t_reset;
        t_prog;
        t_sect;
        t_chip;
        t_misc;
        final_report;
    end
endmodule
`default_nettype wire
